/* rtl/fmtinq_cfg.svh */
// constants for the format check and inquiry command block
`ifndef FMTINQ_CFG_SVH
`define FMTINQ_CFG_SVH
`define OFF_CTRL 12'h000
`define OFF_CDB_LO 12'h004
`define OFF_CDB_HI 12'h008
`define OFF_HDR 12'h00c
`define OFF_DESC_HI 12'h010
`define OFF_DESC_LO 12'h014
`define OFF_EVENT 12'h018
`define OFF_STATUS 12'h01c
`define OFF_SENSE 12'h020
`define OFF_INQ_DATA 12'h024
`define OFF_ID_VENDOR 12'h028
`define OP_INQUIRY 8'h12
`define OP_FORMAT 8'h04
`define INQ_FULL_LEN 8'h24
`define INQ_ADD_LEN 8'h1f
`define INQ_VERSION 8'h01
`define INQ_RESP_FMT 8'h01
`define INQ_SENSE_LEN 8'h12
`define PDT_DISK 8'h00
`define PDT_NO_LUN 8'h7f
`define ASCII_SPACE 8'h20
`define ID_WORD 32'h41424344 // arbitrary value
`define ID_VENDOR_CHAR 8'h56 // arbitrary value
`define ID_PRODUCT_CHAR 8'h50 // arbitrary value
`define ID_REV_CHAR 8'h31 // arbitrary value
`define REMOVABLE_MEDIA_FLAG 1'b0
`define KEY_NONE 4'h0
`define KEY_RECOVERED 4'h1
`define KEY_MEDIUM 4'h3
`define KEY_ILLEGAL 4'h5
`define CODE_NONE 8'h00
`define CODE_BAD_CDB 8'h24
`define CODE_BAD_PARAM 8'h26
`define CODE_LIST_ERR 8'h19
`define CODE_NO_SPARE 8'h32
`define CODE_NO_FACTORY 8'h1c
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define HDR_OPT_VALID 15
`define HDR_SKIP_FACT 14
`define HDR_SKIP_VER 13
`define HDR_HALT 12
`define CDB_FMT_DATA 4
`define CDB_CMP_LIST 3
`define CDB_LIST_FMT_HI 2
`define CDB_LIST_FMT_LO 0
`define LIST_FMT_INDEX 3'h4
`define LIST_FMT_PHYS 3'h5
`define CTRL_GO 0
`define CTRL_FINISH 1
`define CTRL_UA_CLR 2
`define CTRL_UA_SET 3
`define EVENT_DONE 0
`endif

/* rtl/fmtinq_pkg.sv */
// types for the format check and inquiry command block
package fmtinq_pkg;
  typedef enum logic [1:0] {ph_idle, ph_format, ph_inquiry} cmd_phase_t;
  typedef struct packed {
    logic [3:0] key;
    logic [7:0] code;
  } sense_t;
endpackage

/* rtl/inq_rom_if.sv */
// interface between the controller and the inquiry response byte source
interface inq_rom_if;
  logic [5:0] index;
  logic lun_ok;
  logic [7:0] data;
  modport ctrl (output index, output lun_ok, input data);
  modport rom (input index, input lun_ok, output data);
endinterface

/* rtl/inq_rom.sv */
// inquiry response byte source, 36 bytes
`include "fmtinq_cfg.svh"
module inq_rom
  import fmtinq_pkg::*;
(
  inq_rom_if.rom rif
);
  // ***********************************
  // response layout
  // ***********************************
  always_comb begin
    case (rif.index)
      6'd0: rif.data = rif.lun_ok ? `PDT_DISK : `PDT_NO_LUN;
      6'd1: rif.data = {`REMOVABLE_MEDIA_FLAG, 7'h00};
      6'd2: rif.data = `INQ_VERSION;
      6'd3: rif.data = `INQ_RESP_FMT;
      6'd4: rif.data = `INQ_ADD_LEN;
      6'd5: rif.data = `INQ_SENSE_LEN;
      6'd8, 6'd9, 6'd10, 6'd11: rif.data = `ID_VENDOR_CHAR;
      6'd16, 6'd17, 6'd18, 6'd19: rif.data = `ID_PRODUCT_CHAR;
      6'd32, 6'd33, 6'd34, 6'd35: rif.data = `ID_REV_CHAR;
      default: rif.data = (rif.index >= 6'd6 && rif.index <= 6'd7) || rif.index > 6'd35 ? 8'h00 : `ASCII_SPACE;
    endcase
  end
endmodule

/* rtl/fmtinq_core.sv */
// format check and inquiry command interpreter with apb registers
// How it works
// - physical defect descriptor: cylinder bytes 0-2, head byte 3, sector bytes 4-7
// - invalid format mode ends check condition, 05h/24h or 05h/26h
// - halt on list error set: list access failure aborts with 03h/19h
// - too few spares ends format with check condition 03h/32h
// - halt clear: list error continues, ends with recovered 01h/19h
// - options valid clear with any option bit set rejects with 05h/26h
// - halt set, factory list used and missing: 05h/1Ch
// - halt clear, factory list missing: continue, end with 01h/1Ch
// - inquiry under pending unit attention gives good status, attention stays
// - inquiry to nonzero lun still returns data with good status
// - inquiry block six bytes, opcode 12h, allocation length in byte 4; the code reads it from byte 3 (OFF_CDB_HI bits 7:0)
// - allocation length zero sends no data, no error
// - transfer stops at smaller of allocation length and available data
// - full inquiry response is 36 bytes
// - response layout: version 01h, format, length 1Fh, sense length, id fields
// - byte 0 is zero for lun zero, 7Fh otherwise
// - defect list is four byte header then eight byte descriptors
// - halt on list error honoured only with options valid set
//
// The register offsets and the APB slave port were left to the implementer.
`include "fmtinq_cfg.svh"
module fmtinq_core
  import fmtinq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic list_access_err,
  input wire logic factory_list_missing,
  input wire logic spare_exhausted,
  output logic busy
);
  // ***********************************
  // apb decode
  // ***********************************
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `OFF_CTRL, `OFF_CDB_LO, `OFF_CDB_HI, `OFF_HDR, `OFF_DESC_HI, `OFF_DESC_LO,
      `OFF_EVENT, `OFF_STATUS, `OFF_SENSE, `OFF_INQ_DATA, `OFF_ID_VENDOR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  logic [23:0] cdb_lo_q;
  logic [23:0] cdb_hi_q;
  logic [15:0] hdr_q;
  logic [31:0] desc_hi_q;
  logic [31:0] desc_lo_q;
  logic [31:0] prev_hi_q;
  logic [31:0] prev_lo_q;
  logic have_prev_q;
  logic ua_pending_q;
  cmd_phase_t phase_q;
  logic [7:0] status_q;
  logic done_q;
  sense_t sense_q;
  logic list_err_q;
  logic factory_err_q;
  logic [7:0] xfer_left_q;
  logic [5:0] xfer_idx_q;
  logic [7:0] inq_byte_q;
  logic inq_valid_q;
  logic lun_ok_q;

  // ***********************************
  // command block fields
  // ***********************************
  logic [7:0] opcode;
  logic [2:0] cdb_lun;
  logic [7:0] alloc_len;
  logic [7:0] fmt_b1;
  logic options_valid_flag;
  logic skip_factory_list;
  logic skip_verify_pass;
  logic halt_on_list_error;
  assign opcode = cdb_lo_q[7:0];
  assign fmt_b1 = cdb_lo_q[15:8];
  assign cdb_lun = cdb_lo_q[15:13];
  assign alloc_len = cdb_hi_q[7:0];
  assign options_valid_flag = hdr_q[`HDR_OPT_VALID];
  assign skip_factory_list = options_valid_flag && hdr_q[`HDR_SKIP_FACT];
  assign skip_verify_pass = hdr_q[`HDR_SKIP_VER];
  assign halt_on_list_error = options_valid_flag && hdr_q[`HDR_HALT];

  function automatic logic [7:0] min_len(input logic [7:0] a);
    min_len = a < `INQ_FULL_LEN ? a : `INQ_FULL_LEN;
  endfunction

  function automatic logic fmt_mode_bad(input logic [7:0] b1);
    fmt_mode_bad = b1[`CDB_FMT_DATA] &&
      (b1[`CDB_LIST_FMT_HI:`CDB_LIST_FMT_LO] != `LIST_FMT_INDEX) &&
      (b1[`CDB_LIST_FMT_HI:`CDB_LIST_FMT_LO] != `LIST_FMT_PHYS);
  endfunction

  // ***********************************
  // command start and unit attention
  // ***********************************
  logic go;
  logic desc_wr;
  logic finish;
  logic [7:0] first_len;
  assign go = wr_en && paddr == `OFF_CTRL && pwdata[`CTRL_GO] && phase_q == ph_idle;
  assign desc_wr = wr_en && paddr == `OFF_DESC_LO && phase_q == ph_format;
  assign finish = wr_en && paddr == `OFF_CTRL && pwdata[`CTRL_FINISH] && phase_q == ph_format;
  assign first_len = min_len(alloc_len);
  assign busy = phase_q != ph_idle;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ua_pending_q <= 1'b1;
    end else if (wr_en && paddr == `OFF_CTRL && pwdata[`CTRL_UA_CLR]) begin
      ua_pending_q <= 1'b0;
    end else if (wr_en && paddr == `OFF_CTRL && pwdata[`CTRL_UA_SET]) begin
      ua_pending_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdb_lo_q <= 24'h0;
      cdb_hi_q <= 24'h0;
      hdr_q <= 16'h0;
      desc_hi_q <= 32'h0;
      desc_lo_q <= 32'h0;
    end else if (wr_en) begin
      if (paddr == `OFF_CDB_LO && phase_q == ph_idle) cdb_lo_q <= pwdata[23:0];
      if (paddr == `OFF_CDB_HI && phase_q == ph_idle) cdb_hi_q <= pwdata[23:0];
      if (paddr == `OFF_HDR && phase_q == ph_idle) hdr_q <= pwdata[15:0];
      if (paddr == `OFF_DESC_HI) desc_hi_q <= pwdata;
      if (paddr == `OFF_DESC_LO) desc_lo_q <= pwdata;
    end
  end

  // ***********************************
  // defect order check
  // ***********************************
  logic desc_out_of_order;
  assign desc_out_of_order = have_prev_q && ({desc_hi_q, pwdata} <= {prev_hi_q, prev_lo_q});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_hi_q <= 32'h0;
      prev_lo_q <= 32'h0;
      have_prev_q <= 1'b0;
    end else if (go) begin
      have_prev_q <= 1'b0;
    end else if (desc_wr) begin
      prev_hi_q <= desc_hi_q;
      prev_lo_q <= pwdata;
      have_prev_q <= 1'b1;
    end
  end

  // ***********************************
  // format outcome
  // ***********************************
  logic fmt_reject;
  logic fmt_halt;
  logic fmt_list_ev;
  logic fmt_fact_ev;
  assign fmt_reject = fmt_mode_bad(fmt_b1) ||
    (!options_valid_flag && (hdr_q[`HDR_SKIP_FACT] || skip_verify_pass || hdr_q[`HDR_HALT]));
  assign fmt_list_ev = list_access_err || desc_out_of_order && desc_wr;
  assign fmt_fact_ev = factory_list_missing && !skip_factory_list;
  assign fmt_halt = halt_on_list_error && (fmt_list_ev || fmt_fact_ev) || spare_exhausted;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      list_err_q <= 1'b0;
      factory_err_q <= 1'b0;
    end else if (go) begin
      list_err_q <= 1'b0;
      factory_err_q <= 1'b0;
    end else if (phase_q == ph_format) begin
      if (fmt_list_ev) list_err_q <= 1'b1;
      if (fmt_fact_ev) factory_err_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= ph_idle;
      status_q <= `ST_GOOD;
      sense_q <= '{key: `KEY_NONE, code: `CODE_NONE};
      done_q <= 1'b0;
    end else begin
      if (wr_en && paddr == `OFF_EVENT && pwdata[`EVENT_DONE]) done_q <= 1'b0;
      case (phase_q)
        ph_idle: begin
          if (go && opcode == `OP_INQUIRY) begin
            phase_q <= ph_inquiry;
            status_q <= `ST_GOOD;
          end else if (go && opcode == `OP_FORMAT && fmt_reject) begin
            status_q <= `ST_CHECK;
            sense_q <= '{key: `KEY_ILLEGAL,
                         code: fmt_mode_bad(fmt_b1) ? `CODE_BAD_CDB : `CODE_BAD_PARAM};
            done_q <= 1'b1;
          end else if (go) begin
            phase_q <= ph_format;
          end
        end
        ph_format: begin
          if (fmt_halt) begin
            phase_q <= ph_idle;
            status_q <= `ST_CHECK;
            done_q <= 1'b1;
            if (spare_exhausted) sense_q <= '{key: `KEY_MEDIUM, code: `CODE_NO_SPARE};
            else if (fmt_list_ev) sense_q <= '{key: `KEY_MEDIUM, code: `CODE_LIST_ERR};
            else sense_q <= '{key: `KEY_ILLEGAL, code: `CODE_NO_FACTORY};
          end else if (finish) begin
            phase_q <= ph_idle;
            done_q <= 1'b1;
            if (list_err_q) begin
              status_q <= `ST_CHECK;
              sense_q <= '{key: `KEY_RECOVERED, code: `CODE_LIST_ERR};
            end else if (factory_err_q) begin
              status_q <= `ST_CHECK;
              sense_q <= '{key: `KEY_RECOVERED, code: `CODE_NO_FACTORY};
            end else begin
              status_q <= `ST_GOOD;
            end
          end
        end
        ph_inquiry: begin
          if (xfer_left_q == 8'h0 && !inq_valid_q) begin
            phase_q <= ph_idle;
            done_q <= 1'b1;
          end
        end
        default: phase_q <= ph_idle;
      endcase
    end
  end

  // ***********************************
  // inquiry data transfer
  // ***********************************
  inq_rom_if rif ();
  inq_rom u_rom (.rif(rif.rom));
  assign rif.index = xfer_idx_q;
  assign rif.lun_ok = lun_ok_q;
  logic inq_pop;
  assign inq_pop = rd_en && paddr == `OFF_INQ_DATA && inq_valid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_left_q <= 8'h0;
      xfer_idx_q <= 6'h0;
      inq_byte_q <= 8'h0;
      inq_valid_q <= 1'b0;
      lun_ok_q <= 1'b1;
    end else if (go && opcode == `OP_INQUIRY) begin
      xfer_left_q <= first_len;
      xfer_idx_q <= 6'h0;
      inq_valid_q <= 1'b0;
      lun_ok_q <= cdb_lun == 3'h0;
    end else if (phase_q == ph_inquiry && xfer_left_q != 8'h0 && (!inq_valid_q || inq_pop)) begin
      inq_byte_q <= rif.data;
      inq_valid_q <= 1'b1;
      xfer_idx_q <= xfer_idx_q + 6'h1;
      xfer_left_q <= xfer_left_q - 8'h1;
    end else if (inq_pop) begin
      inq_valid_q <= 1'b0;
    end
  end

  // ***********************************
  // read mux
  // ***********************************
  always_comb begin
    case (paddr)
      `OFF_CDB_LO: prdata = {8'h00, cdb_lo_q};
      `OFF_CDB_HI: prdata = {8'h00, cdb_hi_q};
      `OFF_HDR: prdata = {16'h0000, hdr_q};
      `OFF_DESC_HI: prdata = desc_hi_q;
      `OFF_DESC_LO: prdata = desc_lo_q;
      `OFF_EVENT: prdata = {31'h0, done_q};
      `OFF_STATUS: prdata = {16'h0000, 6'h0, phase_q, status_q};
      `OFF_SENSE: prdata = {20'h00000, sense_q};
      `OFF_INQ_DATA: prdata = {15'h0000, inq_valid_q, xfer_left_q, inq_byte_q};
      `OFF_ID_VENDOR: prdata = `ID_WORD; // arbitrary value
      `OFF_CTRL: prdata = {31'h0, ua_pending_q};
      default: prdata = 32'h0;
    endcase
  end

  // ***********************************
  // checks
  // ***********************************
  property p_ua_kept;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == ph_inquiry && ua_pending_q && !(wr_en && paddr == `OFF_CTRL)) |=> ua_pending_q;
  endproperty
  a_ua_kept: assert property (p_ua_kept) else $error("unit attention lost during inquiry");

  property p_inq_good;
    @(posedge pclk) disable iff (!presetn)
    (go && opcode == `OP_INQUIRY) |=> status_q == `ST_GOOD;
  endproperty
  a_inq_good: assert property (p_inq_good) else $error("inquiry status not good");

  property p_len_cap;
    @(posedge pclk) disable iff (!presetn)
    (go && opcode == `OP_INQUIRY) |=> xfer_left_q <= `INQ_FULL_LEN && xfer_left_q <= $past(alloc_len);
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("inquiry length not truncated");

  property p_zero_len;
    @(posedge pclk) disable iff (!presetn)
    (go && opcode == `OP_INQUIRY && alloc_len == 8'h0) |=> !inq_valid_q [*2];
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("data sent with zero allocation");

  property p_fov_reject;
    @(posedge pclk) disable iff (!presetn)
    (go && opcode == `OP_FORMAT && !options_valid_flag && hdr_q[`HDR_HALT] && !fmt_mode_bad(fmt_b1))
      |=> status_q == `ST_CHECK && sense_q.code == `CODE_BAD_PARAM && phase_q == ph_idle;
  endproperty
  a_fov_reject: assert property (p_fov_reject) else $error("options valid fault not rejected");

  property p_spare;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == ph_format && spare_exhausted) |=> sense_q.key == `KEY_MEDIUM && sense_q.code == `CODE_NO_SPARE;
  endproperty
  a_spare: assert property (p_spare) else $error("spare exhaustion sense wrong");

  property p_halt_list;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == ph_format && halt_on_list_error && list_access_err && !spare_exhausted)
      |=> phase_q == ph_idle && sense_q.code == `CODE_LIST_ERR && sense_q.key == `KEY_MEDIUM;
  endproperty
  a_halt_list: assert property (p_halt_list) else $error("halt on list error not honoured");

  property p_recov_list;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == ph_format && list_err_q && finish && !fmt_halt) |=> sense_q.key == `KEY_RECOVERED;
  endproperty
  a_recov_list: assert property (p_recov_list) else $error("recovered list error missing");

  property p_pdt;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == ph_inquiry && xfer_idx_q == 6'h0 && xfer_left_q != 8'h0 && !inq_valid_q)
      |=> inq_byte_q == (lun_ok_q ? `PDT_DISK : `PDT_NO_LUN);
  endproperty
  a_pdt: assert property (p_pdt) else $error("device type byte wrong");
endmodule

/* verification/media_model.sv */
// media side model: raises defect list and spare faults while the core is busy (format or inquiry)
module media_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic busy,
  input wire logic [2:0] fault,
  input wire logic [3:0] lag,
  output logic list_access_err,
  output logic factory_list_missing,
  output logic spare_exhausted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] run_q;
  // ****************
  // run counter
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 4'h0;
    end else if (!busy) begin
      run_q <= 4'h0;
    end else if (run_q != 4'hf) begin
      run_q <= run_q + 4'h1;
    end
  end
  // faults appear after lag cycles of busy, prompt or slow
  assign {spare_exhausted, factory_list_missing, list_access_err} = (busy && run_q >= lag) ? fault : 3'h0;
endmodule

/* verification/tb.sv */
// self-checking bench for the format check and inquiry block
`include "fmtinq_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb
  import fmtinq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busy, lae, flm, spx;
  logic [2:0] fault = 3'h0;
  logic [3:0] lag = 4'h0;
  logic [33:0] em, mm;
  logic [33:0] eq[$];
  logic [33:0] mq[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #50 pclk = ~pclk;
  fmtinq_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .list_access_err(lae), .factory_list_missing(flm), .spare_exhausted(spx), .busy(busy));
  media_model far (.pclk(pclk), .presetn(presetn), .busy(busy), .fault(fault), .lag(lag),
    .list_access_err(lae), .factory_list_missing(flm), .spare_exhausted(spx));
  // ****************
  // monitor and timeout
  // ****************
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && mq.size() > 0) begin
      em = eq.pop_front();
      mm = mq.pop_front();
      if (mm != 34'h0) `CHK({busy, pslverr, prdata} & mm, em & mm)
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      $display("MISMATCH t=%0t timeout", $time);
      tally_and_finish();
    end
  end
  // ****************
  // bus tasks
  // ****************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e,
                      input logic [33:0] m);
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 34'h0, 34'h0);
  endtask
  task automatic rx(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m);
    xfer(1'b0, a, 32'h0, e, m);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************
  // command tasks
  // ****************
  task automatic inq(input logic [2:0] lun, input logic [7:0] alc);
    int n;
    logic [7:0] x;
    logic [7:0] b [0:7];
    n = (alc > `INQ_FULL_LEN) ? 36 : int'(alc);
    b = '{(lun == 3'h0) ? `PDT_DISK : `PDT_NO_LUN, 8'h00, `INQ_VERSION, `INQ_RESP_FMT, `INQ_ADD_LEN,
          `INQ_SENSE_LEN, 8'h00, 8'h00};
    wr(`OFF_CDB_LO, {16'h0000, lun, 5'h00, `OP_INQUIRY});
    wr(`OFF_CDB_HI, {24'h0, alc});
    wr(`OFF_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      x = (i < 8) ? b[i] : (i < 12) ? `ID_VENDOR_CHAR : (i >= 16 && i < 20) ? `ID_PRODUCT_CHAR :
          (i >= 32) ? `ID_REV_CHAR : `ASCII_SPACE;
      rx(`OFF_INQ_DATA, {2'h2, 15'h0, 1'b1, 8'(n - 1 - i), x}, {2'h3, 15'h0, 1'b1, 16'hffff});
    end
    rx(`OFF_INQ_DATA, 34'h0, {2'h3, 32'h1ff00});
    rx(`OFF_EVENT, 34'h1, {2'h3, 32'h1});
    rx(`OFF_STATUS, {26'h0, `ST_GOOD}, {2'h3, 32'h3ff});
    wr(`OFF_EVENT, 32'h1);
  endtask
  task automatic fmt(input logic [7:0] c1, input logic [15:0] h, input logic [2:0] f, input logic [1:0] d,
                     input logic [7:0] st, input logic [11:0] sn);
    logic [23:0] cyl;
    cyl = 24'($urandom_range(1000, 2));
    fault <= f;
    lag <= 4'($urandom_range(7, 0));
    wr(`OFF_CDB_LO, {16'h0, c1, `OP_FORMAT});
    wr(`OFF_HDR, {16'h0, h});
    rx(`OFF_HDR, {18'h0, h}, {34{1'b1}});
    wr(`OFF_CTRL, 32'h1);
    if (d != 2'h0) begin
      wr(`OFF_DESC_HI, {cyl, 8'h02});
      wr(`OFF_DESC_LO, 32'h10);
      wr(`OFF_DESC_HI, {(d == 2'h1) ? cyl + 24'h1 : cyl - 24'h1, 8'h00});
      wr(`OFF_DESC_LO, 32'h5);
    end
    repeat (12) @(posedge pclk);
    rx(`OFF_STATUS, 34'h0, 34'h0);
    if (rd[9:8] !== 2'h0) wr(`OFF_CTRL, 32'h2);
    rd = 32'h0;
    for (int k = 0; k < 50 && rd[0] !== 1'b1; k++) rx(`OFF_EVENT, 34'h0, 34'h0);
    rx(`OFF_STATUS, {26'h0, st}, {2'h3, 32'h3ff});
    if (st != `ST_GOOD) rx(`OFF_SENSE, {22'h0, sn}, {22'h300000, 12'hfff});
    wr(`OFF_EVENT, 32'h1);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(68529));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rx(`OFF_CTRL, 34'h1, {2'h3, 32'h1});
    rx(`OFF_STATUS, 34'h0, {2'h3, 32'h3ff});
    rx(12'h0fc, {2'h1, 32'h0}, {34{1'b1}});
    rx(`OFF_ID_VENDOR, {2'h0, `ID_WORD}, {34{1'b1}});
    $display("test reset done");
    inq(3'h0, 8'h24);
    inq(3'h0, 8'h00);
    inq(3'h0, 8'hc8);
    for (int i = 0; i < 4; i++) inq(3'($urandom_range(7, 1)), 8'($urandom_range(35, 1)));
    rx(`OFF_CTRL, 34'h1, {2'h3, 32'h1});
    wr(`OFF_CTRL, 32'h4);
    rx(`OFF_CTRL, 34'h0, {2'h3, 32'h1});
    wr(`OFF_CTRL, 32'h8);
    inq(3'h2, 8'h08);
    rx(`OFF_CTRL, 34'h1, {2'h3, 32'h1});
    $display("test inquiry done");
    fmt(8'h15, 16'hb000, 3'h0, 2'h1, `ST_GOOD, 12'h000);
    fmt(8'h15, 16'hb000, 3'h0, 2'h2, `ST_CHECK, {`KEY_MEDIUM, `CODE_LIST_ERR});
    fmt(8'h15, 16'hb000, 3'h1, 2'h0, `ST_CHECK, {`KEY_MEDIUM, `CODE_LIST_ERR});
    fmt(8'h15, 16'ha000, 3'h1, 2'h1, `ST_CHECK, {`KEY_RECOVERED, `CODE_LIST_ERR});
    fmt(8'h15, 16'ha000, 3'h4, 2'h0, `ST_CHECK, {`KEY_MEDIUM, `CODE_NO_SPARE});
    fmt(8'h15, 16'hb000, 3'h2, 2'h0, `ST_CHECK, {`KEY_ILLEGAL, `CODE_NO_FACTORY});
    fmt(8'h15, 16'ha000, 3'h2, 2'h0, `ST_CHECK, {`KEY_RECOVERED, `CODE_NO_FACTORY});
    fmt(8'h15, 16'hf000, 3'h2, 2'h0, `ST_GOOD, 12'h000);
    fmt(8'h15, 16'h1000, 3'h0, 2'h0, `ST_CHECK, {`KEY_ILLEGAL, `CODE_BAD_PARAM});
    fmt(8'h17, 16'ha000, 3'h0, 2'h0, `ST_CHECK, {`KEY_ILLEGAL, `CODE_BAD_CDB});
    $display("test format done");
    tally_and_finish();
  end
endmodule
